/* hdl/pse_port_trigger_control.v */
`timescale 1ns/10ps
`default_nettype none
`include "pse_trig_defs.vh"

//
// Contract
// R1: writing one to bits 7..4 of 0x10 launches one classification pass.
// R2: each classification retrigger bit clears when its pass finishes.
// R3: writing one to bits 3..0 of 0x10 launches one detection pass.
// R4: each detection retrigger bit clears when its detection completes.
// R5: manual mode runs each requested pass exactly once, never repeating.
// R6: semi and auto modes use detect and class enables, not retrigger bits.
// R7: semi and auto modes repeat enabled detection or classification forever.
// R8: writing one to bits 7..4 of 0x11 powers that port off.
// R9: each power-off bit returns to zero after the shutdown is issued.
// R10: writing one to bits 3..0 of 0x11 starts powering that port.
// R11: power-on bit stays set until start-up completes, then clears.
// R12: with detect enable and power-on set, detection runs before power-up.
// R13: manual mode ignores power-on for ports already powered or shut down.
// R14: semi mode acts on power-on only when detect and class results valid.
// R15: auto mode honours power-on only while legacy detection runs.
// R16: detection, class, legacy or start-up failure clears the power-on bit.
// R17: power-on held 400 ms on an operational port is cleared.
// R18: two-bit legacy mode field per port in 0x12; 00 disables legacy.
// R19: legacy code 01 runs legacy detection instead of standard detection.
// R20: legacy code 10 runs legacy detection after standard detection.
// R21: host must never program the reserved legacy code 11.
// R22: writing zero to trigger bits changes nothing and cancels nothing.
module pse_port_trigger_control #(
  parameter integer TICK_CYCLES = `TICK_CYCLES
) (
  input wire clk_sys_i, // system clock, 40 MHz
  input wire rst_i, // async reset, active high
  input wire reg_wr_i, // register write strobe
  input wire reg_rd_i, // register read strobe
  input wire [7:0] reg_addr_i, // register address
  input wire [7:0] reg_wdata_i, // register write data
  output reg [7:0] reg_rdata_o, // read data, valid after read strobe
  input wire [1:0] op_mode_i, // manual, semi-automatic or automatic
  input wire [3:0] detect_enable_i, // per-port detect enable
  input wire [3:0] class_enable_i, // per-port class enable
  input wire [3:0] results_valid_i, // detect and class results valid
  input wire [3:0] port_powered_i, // port is powered and operational
  input wire [3:0] port_shutdown_i, // port is in shutdown
  input wire [3:0] det_done_i, // standard detection finished
  input wire [3:0] det_ok_i, // standard detection passed
  input wire [3:0] leg_done_i, // legacy detection finished
  input wire [3:0] leg_ok_i, // legacy detection passed
  input wire [3:0] cls_done_i, // classification finished
  input wire [3:0] cls_ok_i, // classification passed
  input wire [3:0] pwr_done_i, // start-up sequence finished
  input wire [3:0] pwr_ok_i, // start-up sequence passed
  output wire [3:0] det_start_o, // pulse: start standard detection
  output wire [3:0] leg_start_o, // pulse: start legacy detection
  output wire [3:0] cls_start_o, // pulse: start classification
  output wire [3:0] pwr_start_o, // pulse: start port power-up
  output reg [3:0] pwr_off_o, // pulse: shut port power off
  output wire [3:0] port_busy_o // a pass or start-up is running
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_DET = 3'h1;
  localparam [2:0] S_LEG = 3'h2;
  localparam [2:0] S_CLS = 3'h3;
  localparam [2:0] S_PWR = 3'h4;

  reg [7:0] retrig;
  reg [7:0] pwr_trig;
  reg [7:0] legacy_sel;

  wire tick;
  wire [3:0] det_bits;
  wire [3:0] cls_bits;
  wire [3:0] pon_bits;
  wire [3:0] poff_bits;
  wire [3:0] det_clr;
  wire [3:0] cls_clr;
  wire [3:0] pon_clr;
  wire [3:0] hold_expire;
  wire wr_retrig;
  wire wr_pwr;
  wire wr_legacy;

  assign det_bits = retrig[`DET_BIT_LSB+3:`DET_BIT_LSB];
  assign cls_bits = retrig[`CLS_BIT_LSB+3:`CLS_BIT_LSB];
  assign pon_bits = pwr_trig[`PON_BIT_LSB+3:`PON_BIT_LSB];
  assign poff_bits = pwr_trig[`POFF_BIT_LSB+3:`POFF_BIT_LSB];

  // address decode for the three trigger registers
  assign wr_retrig = reg_wr_i && (reg_addr_i == `REG_RETRIG_ADDR);
  assign wr_pwr = reg_wr_i && (reg_addr_i == `REG_PWR_TRIG_ADDR);
  assign wr_legacy = reg_wr_i && (reg_addr_i == `REG_LEGACY_ADDR);

  // millisecond time base for the power-on hold limit
  tick_div #(
    .DIV_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // retrigger bits: writes only set, hardware clears; a set in the
  // same cycle as a clear survives so no request is lost
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      retrig <= `REG_RESET_VAL;
    end
    else
    begin
      retrig <= (retrig & ~{cls_clr, det_clr}) // R2 R4
        | (wr_retrig ? reg_wdata_i : 8'h00); // R1 R3 R22
    end
  end

  // power triggers: off bits live one cycle, on bits until cleared
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pwr_trig <= `REG_RESET_VAL;
    end
    else
    begin
      pwr_trig <= (pwr_trig & ~{poff_bits, pon_clr}) // R9 R11
        | (wr_pwr ? reg_wdata_i : 8'h00); // R8 R10 R22
    end
  end

  // legacy mode field is plain storage, four two-bit fields
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      legacy_sel <= `REG_RESET_VAL;
    end
    else if (wr_legacy)
    begin
      legacy_sel <= reg_wdata_i; // R18
    end
  end

  // shutdown pulse follows the power-off bit by one cycle
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pwr_off_o <= 4'h0;
    end
    else
    begin
      pwr_off_o <= poff_bits; // R8
    end
  end

  // read data held in a register; unmapped addresses read zero
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `REG_RETRIG_ADDR: reg_rdata_o <= retrig;
        `REG_PWR_TRIG_ADDR: reg_rdata_o <= pwr_trig;
        `REG_LEGACY_ADDR: reg_rdata_o <= legacy_sel;
        default: reg_rdata_o <= `REG_UNMAPPED_VAL;
      endcase
    end
  end

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_port
      reg [2:0] st;
      reg [2:0] next_st;
      reg pwr_after;
      reg next_pwr_after;
      reg det_trig;
      reg next_det_trig;
      reg cls_trig;
      reg next_cls_trig;
      reg go_det;
      reg go_leg;
      reg go_cls;
      reg go_pwr;
      reg clr_det;
      reg clr_cls;
      reg clr_pon;
      reg det_start_q;
      reg leg_start_q;
      reg cls_start_q;
      reg pwr_start_q;
      reg busy_q;
      wire manual;
      wire semi;
      wire autom;
      wire [1:0] legm;
      wire leg_only;
      wire leg_after;
      wire det_want;
      wire cls_want;
      wire pon_ok;

      assign manual = (op_mode_i == `OPMODE_MANUAL);
      assign semi = (op_mode_i == `OPMODE_SEMI);
      assign autom = !manual && !semi;
      // reserved code 11 falls back to standard detection only
      assign legm = legacy_sel[2*i+1:2*i];
      assign leg_only = (legm == `LEG_MODE_ONLY); // R19
      assign leg_after = (legm == `LEG_MODE_AFTER); // R20

      // manual mode uses retrigger bits, other modes the enables
      assign det_want = manual ? det_bits[i] : detect_enable_i[i]; // R6
      assign cls_want = manual ? cls_bits[i] : class_enable_i[i]; // R6

      // power-on acceptance per mode; auto acts inside legacy state
      assign pon_ok = manual ? (pon_bits[i] && !port_powered_i[i]
                                && !port_shutdown_i[i]) // R13
                    : semi ? (pon_bits[i] && results_valid_i[i]) // R14
                    : 1'b0; // R15

      // next-state logic of the per-port sequencer
      always @*
      begin
        next_st = st;
        next_pwr_after = pwr_after;
        next_det_trig = det_trig;
        next_cls_trig = cls_trig;
        go_det = 1'b0;
        go_leg = 1'b0;
        go_cls = 1'b0;
        go_pwr = 1'b0;
        clr_det = 1'b0;
        clr_cls = 1'b0;
        clr_pon = 1'b0;
        case (st)
          S_IDLE:
          begin
            if (pon_ok && detect_enable_i[i])
            begin
              // detection ahead of power-up
              next_pwr_after = 1'b1; // R12
              next_det_trig = 1'b0;
              next_st = leg_only ? S_LEG : S_DET;
              go_leg = leg_only;
              go_det = !leg_only;
            end
            else if (pon_ok)
            begin
              go_pwr = 1'b1; // R10
              next_st = S_PWR;
            end
            else if (det_want)
            begin
              // enables re-enter here each pass, so passes repeat
              next_pwr_after = 1'b0;
              next_det_trig = manual; // R5 R7
              next_st = leg_only ? S_LEG : S_DET;
              go_leg = leg_only; // R19
              go_det = !leg_only; // R3
            end
            else if (cls_want)
            begin
              next_cls_trig = manual; // R5 R7
              go_cls = 1'b1; // R1
              next_st = S_CLS;
            end
          end
          S_DET:
          begin
            if (det_done_i[i] && !det_ok_i[i])
            begin
              clr_det = det_trig; // R4
              clr_pon = pon_bits[i]; // R16
              next_st = S_IDLE;
            end
            else if (det_done_i[i] && leg_after)
            begin
              go_leg = 1'b1; // R20
              next_st = S_LEG;
            end
            else if (det_done_i[i])
            begin
              clr_det = det_trig; // R4
              go_pwr = pwr_after; // R12
              next_st = pwr_after ? S_PWR : S_IDLE;
            end
          end
          S_LEG:
          begin
            if (leg_done_i[i] && !leg_ok_i[i])
            begin
              clr_det = det_trig; // R4
              clr_pon = pon_bits[i]; // R16
              next_st = S_IDLE;
            end
            else if (leg_done_i[i] && (pwr_after
                     || (autom && pon_bits[i]))) // R15
            begin
              clr_det = det_trig; // R4
              go_pwr = 1'b1;
              next_st = S_PWR;
            end
            else if (leg_done_i[i])
            begin
              clr_det = det_trig; // R4
              next_st = S_IDLE;
            end
          end
          S_CLS:
          begin
            if (cls_done_i[i])
            begin
              clr_cls = cls_trig; // R2
              clr_pon = !cls_ok_i[i] && pon_bits[i]; // R16
              next_st = S_IDLE;
            end
          end
          S_PWR:
          begin
            if (poff_bits[i])
            begin
              // a shutdown request aborts a start-up in progress
              clr_pon = 1'b1; // R8
              next_st = S_IDLE;
            end
            else if (pwr_done_i[i])
            begin
              clr_pon = 1'b1; // R11 R16
              next_st = S_IDLE;
            end
          end
          default:
          begin
            next_st = S_IDLE;
          end
        endcase
      end

      // state and registered start pulses to the engines
      always @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          st <= S_IDLE;
          pwr_after <= 1'b0;
          det_trig <= 1'b0;
          cls_trig <= 1'b0;
          det_start_q <= 1'b0;
          leg_start_q <= 1'b0;
          cls_start_q <= 1'b0;
          pwr_start_q <= 1'b0;
          busy_q <= 1'b0;
        end
        else
        begin
          st <= next_st;
          pwr_after <= next_pwr_after;
          det_trig <= next_det_trig;
          cls_trig <= next_cls_trig;
          det_start_q <= go_det;
          leg_start_q <= go_leg;
          cls_start_q <= go_cls;
          pwr_start_q <= go_pwr;
          busy_q <= (next_st != S_IDLE);
        end
      end

      // hold limit only runs while the port is up with the bit set
      hold_timer u_hold (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .run_i(pon_bits[i] && port_powered_i[i]),
        .expire_o(hold_expire[i])
      );

      assign det_clr[i] = clr_det;
      assign cls_clr[i] = clr_cls;
      assign pon_clr[i] = clr_pon || hold_expire[i]; // R17
      assign det_start_o[i] = det_start_q;
      assign leg_start_o[i] = leg_start_q;
      assign cls_start_o[i] = cls_start_q;
      assign pwr_start_o[i] = pwr_start_q;
      assign port_busy_o[i] = busy_q;
    end
  endgenerate

endmodule
`default_nettype wire

/* inc/pse_trig_defs.vh */
`ifndef PSE_TRIG_DEFS_VH
`define PSE_TRIG_DEFS_VH

// register addresses on the management register port
`define REG_RETRIG_ADDR 8'h10
`define REG_PWR_TRIG_ADDR 8'h11
`define REG_LEGACY_ADDR 8'h12
`define REG_RESET_VAL 8'h00
`define REG_UNMAPPED_VAL 8'h00

// field positions inside the trigger registers
`define CLS_BIT_LSB 4
`define DET_BIT_LSB 0
`define POFF_BIT_LSB 4
`define PON_BIT_LSB 0

// legacy detection mode codes, two bits per port
`define LEG_MODE_OFF 2'h0
`define LEG_MODE_ONLY 2'h1
`define LEG_MODE_AFTER 2'h2
`define LEG_MODE_RSVD 2'h3

// device operating modes
`define OPMODE_MANUAL 2'h0
`define OPMODE_SEMI 2'h1
`define OPMODE_AUTO 2'h2

// timing: one millisecond tick from the 40 MHz system clock
`define CLK_FREQ_KHZ 40000
`define TICK_TIME_MS 1
`define TICK_CYCLES (`CLK_FREQ_KHZ * `TICK_TIME_MS)
`define PON_HOLD_TIME_MS 400
`define PON_HOLD_TICKS (`PON_HOLD_TIME_MS / `TICK_TIME_MS)

`endif

/* hdl/tick_div.v */
`timescale 1ns/10ps
`default_nettype none

// divider giving a one-cycle enable pulse every div_cycles clocks
module tick_div #(
  parameter integer DIV_CYCLES = 40000
) (
  input wire clk_sys_i, // system clock
  input wire rst_i, // async reset, active high
  output reg tick_o // one-cycle enable pulse
);

  localparam integer LAST = DIV_CYCLES - 1;

  reg [15:0] cnt;

  // free running count; limited to 65536 cycles per tick
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt <= 16'h0000;
      tick_o <= 1'b0;
    end
    else if (cnt == LAST[15:0])
    begin
      cnt <= 16'h0000;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 16'h0001;
      tick_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* hdl/hold_timer.v */
`timescale 1ns/10ps
`default_nettype none
`include "pse_trig_defs.vh"

// counts ticks while run_i stays high, pulses at the hold limit and restarts the count
module hold_timer (
  input wire clk_sys_i, // system clock
  input wire rst_i, // async reset, active high
  input wire tick_i, // one-cycle time base enable
  input wire run_i, // condition being timed
  output reg expire_o // one-cycle pulse at the limit
);

  localparam integer LAST = `PON_HOLD_TICKS - 1;

  reg [8:0] cnt;

  // restart whenever the condition drops, so only a steady hold expires
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt <= 9'h000;
      expire_o <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt <= 9'h000;
      expire_o <= 1'b0;
    end
    else if (tick_i)
    begin
      if (cnt == LAST[8:0])
      begin
        cnt <= 9'h000;
        expire_o <= 1'b1;
      end
      else
      begin
        cnt <= cnt + 9'h001;
        expire_o <= 1'b0;
      end
    end
    else
    begin
      expire_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* tb/pse_trig_props.sv */
`timescale 1ns/10ps
`default_nettype none

// port-level checks of the trigger block, one clock domain
module pse_trig_props (
  input wire logic clk_sys_i, // clock
  input wire logic rst_i, // reset
  input wire logic reg_wr_i, // write strobe
  input wire logic [7:0] reg_addr_i, // address
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic [1:0] op_mode_i, // mode
  input wire logic [3:0] detect_enable_i, // detect enables
  input wire logic [3:0] class_enable_i, // class enables
  input wire logic [3:0] results_valid_i, // results valid
  input wire logic [3:0] port_powered_i, // powered
  input wire logic [3:0] port_shutdown_i, // shut down
  input wire logic [3:0] leg_done_i, // legacy done
  input wire logic [3:0] det_start_o, // detect start
  input wire logic [3:0] leg_start_o, // legacy start
  input wire logic [3:0] cls_start_o, // class start
  input wire logic [3:0] pwr_start_o, // power-up start
  input wire logic [3:0] pwr_off_o, // power-off pulse
  input wire logic [3:0] port_busy_o // busy
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // host write to the power trigger register
  sequence wr_pwr;
    reg_wr_i && reg_addr_i == 8'h11;
  endsequence
  // automatic modes with all enables off, long enough to cover a decision
  sequence no_enable;
    (op_mode_i != 2'h0 && detect_enable_i == 4'h0
      && class_enable_i == 4'h0) [*3];
  endsequence
  property off_p;
    logic [3:0] w;
    (wr_pwr, w = reg_wdata_i[7:4]) |-> ##2 (pwr_off_o & w) == w;
  endproperty
  off_pulse_a: assert property (off_p)
    else $error("power-off pulse missing after trigger write");
  off_cause_a: assert property (pwr_off_o != 4'h0 |->
    $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == 8'h11)
    else $error("power-off pulse without a trigger write");
  det_width_a: assert property ((det_start_o & $past(det_start_o)) == 4'h0)
    else $error("detect start longer than one cycle");
  busy_follow_a: assert property (pwr_start_o != 4'h0 |=>
    (port_busy_o & $past(pwr_start_o)) == $past(pwr_start_o))
    else $error("port not busy after power-up start");
  manual_block_a: assert property (op_mode_i == 2'h0 ##1
    op_mode_i == 2'h0 |-> (pwr_start_o & ($past(port_powered_i)
    | $past(port_shutdown_i))) == 4'h0)
    else $error("power-up started on a powered or shut-down port");
  semi_gate_a: assert property (op_mode_i == 2'h1 ##1 op_mode_i == 2'h1
    |-> (pwr_start_o & ~$past(results_valid_i)) == 4'h0)
    else $error("semi mode power-up without valid results");
  auto_gate_a: assert property (op_mode_i == 2'h2 ##1 op_mode_i == 2'h2
    |-> (pwr_start_o & ~$past(leg_done_i)) == 4'h0)
    else $error("auto mode power-up outside legacy detection");
  retrig_ignored_a: assert property (no_enable |->
    (det_start_o | leg_start_o | cls_start_o) == 4'h0)
    else $error("pass started with enables off in automatic mode");
endmodule

bind pse_port_trigger_control pse_trig_props chk (.clk_sys_i, .rst_i,
  .reg_wr_i, .reg_addr_i, .reg_wdata_i, .op_mode_i, .detect_enable_i,
  .class_enable_i, .results_valid_i, .port_powered_i, .port_shutdown_i,
  .leg_done_i, .det_start_o, .leg_start_o, .cls_start_o, .pwr_start_o,
  .pwr_off_o, .port_busy_o);
`default_nettype wire

/* tb/pse_engine_model.sv */
`timescale 1ns/10ps
`default_nettype none

// stands in for one analog engine group: each start gives a done pulse
// delay_i cycles later; the outcome is only meaningful with done
module pse_engine_model (
  input wire logic clk_sys_i, // clock
  input wire logic rst_i, // reset
  input wire logic [3:0] start_i, // start pulses
  input wire logic [3:0] ok_cfg_i, // outcome per port
  input wire logic [7:0] delay_i, // start to done, at least 1
  output logic [3:0] done_o, // done pulse
  output logic [3:0] ok_o // outcome with done
);
  logic [7:0] cnt [4];
  // inverse outcome between done pulses so a stale sample is caught
  assign ok_o = ok_cfg_i ^ ~done_o;
  // one countdown per port
  always @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
    begin
      done_o <= 4'h0;
      for (int i = 0; i < 4; i++)
        cnt[i] <= 8'h00;
    end
    else
      for (int i = 0; i < 4; i++)
      begin
        done_o[i] <= cnt[i] == 8'h01 && !start_i[i];
        if (start_i[i])
          cnt[i] <= delay_i;
        else if (cnt[i] != 8'h00)
          cnt[i] <= cnt[i] - 8'h01;
      end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, dly = 8'h08;
  logic [1:0] op_mode_i = 2'h0;
  logic [3:0] detect_enable_i = 4'h0, class_enable_i = 4'h0;
  logic [3:0] results_valid_i = 4'h0, port_powered_i = 4'h0;
  logic [3:0] port_shutdown_i = 4'h0, det_okc = 4'hF;
  wire [7:0] reg_rdata_o;
  wire [3:0] det_done_i, det_ok_i, leg_done_i, leg_ok_i, cls_done_i;
  wire [3:0] cls_ok_i, pwr_done_i, pwr_ok_i, det_start_o, leg_start_o;
  wire [3:0] cls_start_o, pwr_start_o, pwr_off_o, port_busy_o;
  int failures = 0, tests_run = 0;
  integer seed = 32'h3efe;
  int n_det[4], n_leg[4], n_cls[4], n_pwr[4], n_off[4];
  int e_det[4], e_leg[4], e_cls[4], e_pwr[4], e_off[4];
  logic [7:0] expq[$];
  logic rd_seen = 1'b0;
  logic [7:0] v;

  always #12.5 clk_sys_i = ~clk_sys_i;

  pse_port_trigger_control #(.TICK_CYCLES(4)) uut (.clk_sys_i, .rst_i,
    .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .op_mode_i, .detect_enable_i, .class_enable_i, .results_valid_i,
    .port_powered_i, .port_shutdown_i, .det_done_i, .det_ok_i,
    .leg_done_i, .leg_ok_i, .cls_done_i, .cls_ok_i, .pwr_done_i,
    .pwr_ok_i, .det_start_o, .leg_start_o, .cls_start_o, .pwr_start_o,
    .pwr_off_o, .port_busy_o);
  pse_engine_model det_eng (.clk_sys_i, .rst_i, .start_i(det_start_o),
    .ok_cfg_i(det_okc), .delay_i(dly), .done_o(det_done_i), .ok_o(det_ok_i));
  pse_engine_model leg_eng (.clk_sys_i, .rst_i, .start_i(leg_start_o),
    .ok_cfg_i(4'hF), .delay_i(dly), .done_o(leg_done_i), .ok_o(leg_ok_i));
  pse_engine_model cls_eng (.clk_sys_i, .rst_i, .start_i(cls_start_o),
    .ok_cfg_i(4'hF), .delay_i(dly), .done_o(cls_done_i), .ok_o(cls_ok_i));
  pse_engine_model pwr_eng (.clk_sys_i, .rst_i, .start_i(pwr_start_o),
    .ok_cfg_i(4'hF), .delay_i(dly), .done_o(pwr_done_i), .ok_o(pwr_ok_i));

  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // strobe drops one edge before the next access may raise it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic inc(inout int a[4], input logic [3:0] m);
    for (int i = 0; i < 4; i++)
      a[i] += m[i];
  endtask
  // busy dips for one cycle between a detect and a class pass, so only
  // a run of quiet cycles counts as idle
  task automatic idle();
    int k, q;
    k = 0;
    q = 0;
    while (q < 4 && k < 3000)
    begin
      @(posedge clk_sys_i);
      k++;
      q = (port_busy_o === 4'h0) ? q + 1 : 0;
    end
    chk("busy wait", k < 3000, 1);
  endtask
  task automatic fin(input string name);
    for (int i = 0; i < 4; i++)
    begin
      chk("detect starts", n_det[i], e_det[i]);
      chk("legacy starts", n_leg[i], e_leg[i]);
      chk("class starts", n_cls[i], e_cls[i]);
      chk("power starts", n_pwr[i], e_pwr[i]);
      chk("power offs", n_off[i], e_off[i]);
    end
    $display("test %s finished", name);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // read data is settled by the falling edge after the read is taken
  always @(posedge clk_sys_i)
    rd_seen <= reg_rd_i;
  always @(negedge clk_sys_i)
    if (rd_seen)
      chk("read data", reg_rdata_o, expq.pop_front());
  // count every start and off pulse per port
  always @(posedge clk_sys_i)
    for (int i = 0; i < 4; i++)
    begin
      n_det[i] += det_start_o[i];
      n_leg[i] += leg_start_o[i];
      n_cls[i] += cls_start_o[i];
      n_pwr[i] += pwr_start_o[i];
      n_off[i] += pwr_off_o[i];
    end

  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
    v = $random(seed);
    for (int i = 0; i < 4; i++)
      if (v[2*i +: 2] == 2'h3)
        v[2*i +: 2] = 2'h1;
    wr(8'h12, v);
    wr(8'h13, 8'hFF);
    rd(8'h12, v);
    rd(8'h13, 8'h00);
    wr(8'h12, 8'h00);
    fin("registers");
    // manual one-shot passes; a zero write must not cancel them
    for (int p = 0; p < 4; p++)
    begin
      dly <= 8'h08 + 8'($random(seed) & 15);
      wr(8'h10, 8'h11 << p);
      wr(8'h10, 8'h00);
      rd(8'h10, 8'h11 << p);
      idle();
      rd(8'h10, 8'h00);
      e_det[p]++;
      e_cls[p]++;
    end
    repeat (40) @(posedge clk_sys_i);
    fin("manual retrigger");
    wr(8'h11, 8'hF0);
    rd(8'h11, 8'h00);
    inc(e_off, 4'hF);
    wr(8'h11, 8'h0F);
    rd(8'h11, 8'h0F);
    idle();
    rd(8'h11, 8'h00);
    inc(e_pwr, 4'hF);
    fin("power on and off");
    // powered and shut-down ports keep the request pending
    port_powered_i <= 4'h1;
    port_shutdown_i <= 4'h2;
    wr(8'h11, 8'h03);
    repeat (20) @(posedge clk_sys_i);
    rd(8'h11, 8'h03);
    port_shutdown_i <= 4'h0;
    idle();
    e_pwr[1]++;
    repeat (1650) @(posedge clk_sys_i);
    rd(8'h11, 8'h00);
    port_powered_i <= 4'h0;
    fin("blocked power-on");
    // detect before power-up; failed detects drop the request
    detect_enable_i <= 4'hF;
    det_okc <= 4'hA;
    wr(8'h11, 8'h0F);
    idle();
    rd(8'h11, 8'h00);
    inc(e_det, 4'hF);
    inc(e_pwr, 4'hA);
    detect_enable_i <= 4'h0;
    det_okc <= 4'hF;
    fin("detect then power");
    wr(8'h12, 8'h09);
    wr(8'h10, 8'h0F);
    idle();
    inc(e_leg, 4'h3);
    inc(e_det, 4'hE);
    wr(8'h12, 8'h00);
    fin("legacy modes");
    // semi mode: power-on waits for results, retrigger bits stay idle
    op_mode_i <= 2'h1;
    wr(8'h11, 8'h04);
    repeat (30) @(posedge clk_sys_i);
    results_valid_i <= 4'h4;
    idle();
    inc(e_pwr, 4'h4);
    wr(8'h10, 8'h20);
    detect_enable_i <= 4'h1;
    repeat (300) @(posedge clk_sys_i);
    chk("repeated detects", n_det[0] - e_det[0] > 2, 1);
    rd(8'h10, 8'h20);
    detect_enable_i <= 4'h0;
    idle();
    e_det[0] = n_det[0];
    op_mode_i <= 2'h0;
    idle();
    e_cls[1]++;
    fin("semi mode");
    // auto mode: power-on acts only through legacy detection
    op_mode_i <= 2'h2;
    wr(8'h11, 8'h02);
    wr(8'h12, 8'h01);
    detect_enable_i <= 4'h1;
    wr(8'h11, 8'h01);
    repeat (100) @(posedge clk_sys_i);
    detect_enable_i <= 4'h0;
    idle();
    chk("repeated legacy", n_leg[0] - e_leg[0] > 1, 1);
    e_leg[0] = n_leg[0];
    inc(e_pwr, 4'h1);
    rd(8'h11, 8'h02);
    fin("auto mode");
    end_of_test();
  end

  // watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
